//--- shared/mrlf_pkg.sv
// Package: constants, register map and carrier types of the monitor readout block
`default_nettype none
package mrlf_pkg;
	// Channel set: temperature, supply, three external inputs
	localparam int NUM_CH = 5;
	localparam logic [2:0] CH_TEMP = 3'h0; // Only signed channel
	localparam logic [2:0] CH_LAST = 3'h4;
	// Result word layout
	localparam int RES_W = 16;
	localparam logic [15:0] MASK_20K = 16'hFFF8; // Clears the three lowest bits
	localparam logic [15:0] RES_RST = 16'h0000;
	// Timing at the system clock
	localparam int CLK_KHZ = 125000;
	localparam int FRAME_TYP_MS = 30;
	localparam int FRAME_MAX_MS = 45;
	localparam int FRAME_CYCLES_TYP = FRAME_TYP_MS * CLK_KHZ;
	localparam int FRAME_CYCLES_MAX = FRAME_MAX_MS * CLK_KHZ;
	localparam int SLOT_W = 23; // Holds the longest frame count
	// Register byte offsets
	localparam logic [7:0] ADR_RESULT0 = 8'h00;
	localparam logic [7:0] ADR_LIMIT0 = 8'h20;
	localparam logic [7:0] ADR_LIMIT_END = 8'h6C; // Five channels of four limit words
	// Status and control sit above the limit block so channel four stays reachable
	localparam logic [7:0] ADR_DONE = 8'h80;
	localparam logic [7:0] ADR_CTRL = 8'h84;
	localparam logic [7:0] ADR_STAT = 8'h88;
	localparam logic [7:0] ADR_ALARM = 8'h70;
	localparam logic [7:0] ADR_WARN = 8'h74;
	localparam logic [7:0] ADR_IRQ_ST = 8'h78;
	localparam logic [7:0] ADR_IRQ_MSK = 8'h7C;
	// Control field positions
	localparam int CTRL_LIMIT_OUT_BIT = 0;
	localparam int CTRL_MASK20K_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [4:0] MSK_RST = 5'h00;
	// Limit set of one channel, high and low for alarm and warning
	typedef struct packed {
		logic [15:0] alarm_hi;
		logic [15:0] alarm_lo;
		logic [15:0] warn_hi;
		logic [15:0] warn_lo;
	} mrlf_limits_t;
	// Above-high and below-low pair of one level
	typedef struct packed {
		logic lo;
		logic hi;
	} mrlf_flags_t;
	// Sequencer states
	typedef enum logic [0:0] {
		SEQ_IDLE,
		SEQ_WAIT
	} mrlf_seq_t;
endpackage
`default_nettype wire

//--- hdl/mrlf_sync2.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module mrlf_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Asynchronous level in, synchronous level out
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q; // Read only by the second stage
	// Both stages reset high so protection holds until the pin settles
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= '1;
			q_o <= '1;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule // mrlf_sync2
`default_nettype wire

//--- hdl/mrlf_limit_cmp.sv
// Window comparator of one channel against alarm and warning limits
`timescale 1ns/10ps
`default_nettype none
module mrlf_limit_cmp (
	// Channel format
	input wire logic is_signed_i,
	// Result and limits
	input wire logic [15:0] value_i,
	input wire mrlf_pkg::mrlf_limits_t lim_i,
	// Violations, combinational
	output mrlf_pkg::mrlf_flags_t alarm_o,
	output mrlf_pkg::mrlf_flags_t warn_o
);
	// Flip the sign bit so one unsigned compare serves both formats
	function automatic logic [15:0] key(input logic [15:0] v, input logic s);
		key = {v[15] ^ s, v[14:0]};
	endfunction
	logic [15:0] v_k;
	assign v_k = key(value_i, is_signed_i);
	assign alarm_o.hi = v_k > key(lim_i.alarm_hi, is_signed_i);
	assign alarm_o.lo = v_k < key(lim_i.alarm_lo, is_signed_i);
	assign warn_o.hi = v_k > key(lim_i.warn_hi, is_signed_i);
	assign warn_o.lo = v_k < key(lim_i.warn_lo, is_signed_i);
endmodule // mrlf_limit_cmp
`default_nettype wire

//--- hdl/mrlf_top.sv
// Monitor readout: conversion sequencer, results, limit flags, buffers, Wishbone slave
//
// Contract
// - Each result is 16-bit left-justified, 12 bits good
// - 20k variant forces three lowest bits zero
// - Results refresh round-robin, one per channel per frame
// - Completed conversion sets that channel's done bit
// - Every new result compared to limits, flag set
// - Alarm and warning levels, each with high/low flags
// - Separate interrupt enable for each channel
// - Temperature two's complement, others unsigned full range
// - Count weight is set by factory analog scaling
// - Buffer A output asserted on any alarm violation
// - Two buffers drive open-drain outputs from inputs
// - Write-protect low unprotects; floating input means protected
// - Temperature high byte whole degrees, low byte fraction
// - Frame lasts typically 30 ms, at most 45
// - Alarm flags at 70h, warning flags at 74h
`timescale 1ns/10ps
`default_nettype none
module mrlf_top #(
	parameter int FRAME_CYCLES = mrlf_pkg::FRAME_CYCLES_TYP // Shorten in simulation
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Converter handshake, same clock domain
	output logic conv_start_o,
	output logic [2:0] conv_chan_o,
	input wire logic conv_done_i,
	input wire logic [15:0] conv_data_i,
	// Pins, asynchronous
	input wire logic buffer_a_logic_in,
	input wire logic buffer_b_logic_in,
	input wire logic write_protect_pin,
	// Open-drain outputs: value always low, enable pulls the pin
	output logic buffer_a_open_drain_out,
	output logic buffer_a_open_drain_oe,
	output logic buffer_b_open_drain_out,
	output logic buffer_b_open_drain_oe,
	// Interrupt, level
	output logic irq_o
);
	localparam int NCH = mrlf_pkg::NUM_CH;
	// Per-slot count; the frame is split evenly over the channels
	localparam logic [22:0] SLOT_CYCLES = 23'(FRAME_CYCLES / NCH);

	// Synchronised pin levels
	logic buf_a_s, buf_b_s, wp_s;
	// Sequencer
	mrlf_pkg::mrlf_seq_t seq_q;
	logic [22:0] slot_q; // Cycles into the current slot
	logic [2:0] chan_q; // Channel of this slot
	logic start_q; // One-cycle start pulse
	// Results and compare pipeline
	logic [15:0] res_q [0:NCH-1];
	logic [NCH-1:0] cmp_q; // Channel whose result just landed
	// Limits and flags
	mrlf_pkg::mrlf_limits_t lim_q [0:NCH-1];
	mrlf_pkg::mrlf_flags_t alarm_v [0:NCH-1];
	mrlf_pkg::mrlf_flags_t warn_v [0:NCH-1];
	logic [9:0] alarm_q, warn_q; // Sticky, two bits per channel
	logic [9:0] alarm_set, warn_set;
	logic [NCH-1:0] done_q, irq_st_q, irq_msk_q, irq_set;
	logic [1:0] ctrl_q;
	// Bus
	logic ack_q;
	logic [31:0] dat_q;
	logic acc, wr;
	logic [2:0] lim_ch; // Channel of a limit access
	logic [1:0] lim_k; // Which of the four limits
	logic lim_hit;

	// Pins cross into the clock domain
	mrlf_sync2 #(.W(3)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({buffer_a_logic_in, buffer_b_logic_in, write_protect_pin}),
		.q_o({buf_a_s, buf_b_s, wp_s})
	);

	// One comparator per channel, temperature in signed mode
	for (genvar g = 0; g < NCH; g++) begin : g_cmp
		mrlf_limit_cmp u_cmp (
			.is_signed_i(3'(g) == mrlf_pkg::CH_TEMP),
			.value_i(res_q[g]),
			.lim_i(lim_q[g]),
			.alarm_o(alarm_v[g]),
			.warn_o(warn_v[g])
		);
		// Flags are only set when a fresh result was just stored
		assign alarm_set[2*g +: 2] = cmp_q[g] ? alarm_v[g] : 2'h0;
		assign warn_set[2*g +: 2] = cmp_q[g] ? warn_v[g] : 2'h0;
		assign irq_set[g] = |alarm_set[2*g +: 2] | |warn_set[2*g +: 2];
	end

	// Bus decode
	assign acc = cyc_i && stb_i && !ack_q;
	assign wr = acc && we_i;
	assign lim_hit = adr_i >= mrlf_pkg::ADR_LIMIT0 && adr_i <= mrlf_pkg::ADR_LIMIT_END;
	assign lim_ch = 3'(adr_i[6:4] - 3'h2);
	assign lim_k = adr_i[3:2];

	// Slot timer and round-robin sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_q <= mrlf_pkg::SEQ_IDLE;
			slot_q <= '0;
			chan_q <= mrlf_pkg::CH_TEMP;
			start_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (slot_q >= SLOT_CYCLES - 23'h1) begin
				// Slot over: next channel, wrapping after the last
				slot_q <= '0;
				chan_q <= (chan_q == mrlf_pkg::CH_LAST) ? 3'h0 : 3'(chan_q + 3'h1);
				start_q <= 1'b1;
				seq_q <= mrlf_pkg::SEQ_WAIT;
			end else begin
				slot_q <= slot_q + 23'h1;
			end
			case (seq_q)
				mrlf_pkg::SEQ_IDLE: begin
					// Hold; only the slot edge above may move to waiting
				end
				mrlf_pkg::SEQ_WAIT: begin
					// An answer in the slot's last cycle is still stored, but the slot edge keeps the state waiting
					if (conv_done_i && slot_q < SLOT_CYCLES - 23'h1) begin
						seq_q <= mrlf_pkg::SEQ_IDLE;
					end
				end
				default: begin
					seq_q <= mrlf_pkg::SEQ_IDLE;
				end
			endcase
		end
	end
	assign conv_start_o = start_q;
	assign conv_chan_o = chan_q;

	// Result capture, low bits cleared in the 20k variant
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NCH; i++) begin
				res_q[i] <= mrlf_pkg::RES_RST;
			end
			cmp_q <= '0;
		end else begin
			cmp_q <= '0;
			if (seq_q == mrlf_pkg::SEQ_WAIT && conv_done_i) begin
				// Left-justified word stored, three lowest bits cleared in the 20k variant; format set by scaling
				res_q[chan_q] <= ctrl_q[mrlf_pkg::CTRL_MASK20K_BIT]
					? (conv_data_i & mrlf_pkg::MASK_20K) : conv_data_i;
				cmp_q[chan_q] <= 1'b1;
			end
		end
	end

	// Conversion-done bits, set beats a write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_q <= '0;
		end else begin
			done_q <= (done_q & ~((wr && adr_i == mrlf_pkg::ADR_DONE && sel_i[0])
				? dat_i[NCH-1:0] : '0)) | cmp_q;
		end
	end

	// Sticky alarm and warning flags, write one to clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alarm_q <= '0;
			warn_q <= '0;
		end else begin
			alarm_q <= (alarm_q & ~((wr && adr_i == mrlf_pkg::ADR_ALARM)
				? dat_i[9:0] : 10'h000)) | alarm_set;
			warn_q <= (warn_q & ~((wr && adr_i == mrlf_pkg::ADR_WARN)
				? dat_i[9:0] : 10'h000)) | warn_set;
		end
	end

	// Interrupt status and per-channel enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_st_q <= '0;
			irq_msk_q <= mrlf_pkg::MSK_RST;
		end else begin
			irq_st_q <= (irq_st_q & ~((wr && adr_i == mrlf_pkg::ADR_IRQ_ST)
				? dat_i[NCH-1:0] : '0)) | irq_set;
			if (wr && adr_i == mrlf_pkg::ADR_IRQ_MSK && sel_i[0]) begin
				irq_msk_q <= dat_i[NCH-1:0];
			end
		end
	end
	assign irq_o = |(irq_st_q & irq_msk_q);

	// Limits, refused while the protect pin is high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NCH; i++) begin
				lim_q[i] <= '0;
			end
		end else if (wr && lim_hit && !wp_s) begin
			// Low lane then high lane of the 16-bit limit
			case (lim_k)
				2'h0: begin
					if (sel_i[0]) lim_q[lim_ch].alarm_hi[7:0] <= dat_i[7:0];
					if (sel_i[1]) lim_q[lim_ch].alarm_hi[15:8] <= dat_i[15:8];
				end
				2'h1: begin
					if (sel_i[0]) lim_q[lim_ch].alarm_lo[7:0] <= dat_i[7:0];
					if (sel_i[1]) lim_q[lim_ch].alarm_lo[15:8] <= dat_i[15:8];
				end
				2'h2: begin
					if (sel_i[0]) lim_q[lim_ch].warn_hi[7:0] <= dat_i[7:0];
					if (sel_i[1]) lim_q[lim_ch].warn_hi[15:8] <= dat_i[15:8];
				end
				default: begin
					if (sel_i[0]) lim_q[lim_ch].warn_lo[7:0] <= dat_i[7:0];
					if (sel_i[1]) lim_q[lim_ch].warn_lo[15:8] <= dat_i[15:8];
				end
			endcase
		end
	end

	// Control bits, also under write protection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= mrlf_pkg::CTRL_RST;
		end else if (wr && adr_i == mrlf_pkg::ADR_CTRL && sel_i[0] && !wp_s) begin
			ctrl_q <= dat_i[1:0];
		end
	end

	// Read data and acknowledge, one wait state for every access
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end else begin
			ack_q <= acc;
			if (acc && !we_i) begin
				dat_q <= '0; // Unmapped reads zero
				if (adr_i < mrlf_pkg::ADR_LIMIT0 && adr_i[4:2] <= mrlf_pkg::CH_LAST
					&& adr_i[7:5] == 3'h0) begin
					dat_q <= {16'h0000, res_q[adr_i[4:2]]};
				end else if (lim_hit) begin
					case (lim_k)
						2'h0: dat_q <= {16'h0000, lim_q[lim_ch].alarm_hi};
						2'h1: dat_q <= {16'h0000, lim_q[lim_ch].alarm_lo};
						2'h2: dat_q <= {16'h0000, lim_q[lim_ch].warn_hi};
						default: dat_q <= {16'h0000, lim_q[lim_ch].warn_lo};
					endcase
				end else begin
					case (adr_i)
						mrlf_pkg::ADR_DONE: dat_q <= {27'h0000000, done_q};
						mrlf_pkg::ADR_CTRL: dat_q <= {30'h00000000, ctrl_q};
						mrlf_pkg::ADR_STAT: dat_q <= {25'h0000000, chan_q, 3'h0, wp_s};
						mrlf_pkg::ADR_ALARM: dat_q <= {22'h000000, alarm_q};
						mrlf_pkg::ADR_WARN: dat_q <= {22'h000000, warn_q};
						mrlf_pkg::ADR_IRQ_ST: dat_q <= {27'h0000000, irq_st_q};
						mrlf_pkg::ADR_IRQ_MSK: dat_q <= {27'h0000000, irq_msk_q};
						default: dat_q <= '0;
					endcase
				end
			end
		end
	end
	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// Open-drain buffers; buffer A also pulled by any alarm when enabled
	assign buffer_a_open_drain_out = 1'b0;
	assign buffer_b_open_drain_out = 1'b0;
	assign buffer_a_open_drain_oe = !buf_a_s
		|| (ctrl_q[mrlf_pkg::CTRL_LIMIT_OUT_BIT] && |alarm_q);
	assign buffer_b_open_drain_oe = !buf_b_s;
endmodule // mrlf_top
`default_nettype wire

//--- verification/mrlf_conv_model.sv
// Converter model: answers each start with a result after a set delay
`timescale 1ns/10ps
`default_nettype none
module mrlf_conv_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Handshake with the block
	input wire logic conv_start_i,
	input wire logic [2:0] conv_chan_i,
	output logic conv_done_o,
	output logic [15:0] conv_data_o,
	// Bench controls: delay and one result per channel
	input wire logic [3:0] delay_i,
	input wire logic [4:0][15:0] tab_i
);
	logic [3:0] cnt_q; // Cycles left until the answer
	// Count down from a start and answer at one
	always_ff @(posedge clk_i) begin
		conv_done_o <= 1'b0;
		conv_data_o <= ~conv_data_o; // Data is junk outside done
		if (rst_i) begin
			cnt_q <= 4'h0;
			conv_data_o <= 16'h0000;
		end else if (conv_start_i) begin
			cnt_q <= delay_i;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h1) begin
				conv_done_o <= 1'b1;
				conv_data_o <= tab_i[conv_chan_i];
			end
		end
	end
endmodule // mrlf_conv_model
`default_nettype wire

//--- verification/mrlf_checker.sv
// Checker: bus, sequencer and buffer relations at the top ports
`timescale 1ns/10ps
`default_nettype none
module mrlf_checker #(
	parameter int FRAME_CYCLES = 50
) (
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Sequencer
	input wire logic conv_start_o,
	input wire logic [2:0] conv_chan_o,
	// Buffers
	input wire logic buffer_a_logic_in,
	input wire logic buffer_b_logic_in,
	input wire logic buffer_a_open_drain_out,
	input wire logic buffer_a_open_drain_oe,
	input wire logic buffer_b_open_drain_out,
	input wire logic buffer_b_open_drain_oe
);
	localparam int SLOT = FRAME_CYCLES / 5;
	logic [22:0] gap_q; // Cycles since the last start
	logic [2:0] prev_q; // Channel of the last start
	logic seen_q; // A start seen since reset
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Gap counter, cleared by each start
	always_ff @(posedge clk_i) begin
		gap_q <= (rst_i || conv_start_o) ? 23'h0 : gap_q + 23'h1;
	end
	// Last channel; reset value 0 makes channel 1 the first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_q <= 3'h0;
			seen_q <= 1'b0;
		end else if (conv_start_o) begin
			prev_q <= conv_chan_o;
			seen_q <= 1'b1;
		end
	end
	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_due;
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	a_ack_due: assert property (p_ack_due) else $error("ack late");
	property p_dat_hold;
		$changed(dat_o) |-> ack_o;
	endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
	property p_start_gap;
		conv_start_o && seen_q |-> gap_q == SLOT - 1;
	endproperty
	a_start_gap: assert property (p_start_gap) else $error("slot length");
	property p_start_due;
		seen_q |-> gap_q < SLOT;
	endproperty
	a_start_due: assert property (p_start_due) else $error("start missing");
	property p_chan_next;
		conv_start_o |-> conv_chan_o == ((prev_q == 3'h4) ? 3'h0 : prev_q + 3'h1);
	endproperty
	a_chan_next: assert property (p_chan_next) else $error("channel order");
	property p_chan_hold;
		!conv_start_o |-> $stable(conv_chan_o);
	endproperty
	a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
	property p_buf_b;
		$stable(buffer_b_logic_in) [*3] |=>
			buffer_b_open_drain_oe == !$past(buffer_b_logic_in);
	endproperty
	a_buf_b: assert property (p_buf_b) else $error("buffer b level");
	property p_buf_a_low;
		!buffer_a_logic_in [*3] |=> buffer_a_open_drain_oe;
	endproperty
	a_buf_a_low: assert property (p_buf_a_low) else $error("buffer a level");
	property p_od_low;
		!(buffer_a_open_drain_out || buffer_b_open_drain_out);
	endproperty
	a_od_low: assert property (p_od_low) else $error("open drain drives high");
endmodule // mrlf_checker
bind mrlf_top mrlf_checker #(.FRAME_CYCLES(FRAME_CYCLES)) i_chk (.clk_i, .rst_i, .cyc_i,
	.stb_i, .dat_o, .ack_o, .conv_start_o, .conv_chan_o, .buffer_a_logic_in,
	.buffer_b_logic_in, .buffer_a_open_drain_out, .buffer_a_open_drain_oe,
	.buffer_b_open_drain_out, .buffer_b_open_drain_oe);
`default_nettype wire

//--- verification/test_monitor_readout_limit_flags.sv
// Testbench: results, flags, interrupt and buffers over Wishbone
`timescale 1ns/10ps
`default_nettype none
module test_monitor_readout_limit_flags;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, conv_start_o, conv_done_i;
	logic buffer_a_logic_in, buffer_b_logic_in, write_protect_pin;
	logic buffer_a_open_drain_out, buffer_a_open_drain_oe;
	logic buffer_b_open_drain_out, buffer_b_open_drain_oe;
	logic [7:0] adr_i;
	logic [3:0] sel_i, dly;
	logic [31:0] dat_i, dat_o;
	logic [2:0] conv_chan_o;
	logic [15:0] conv_data_i;
	logic [4:0][15:0] tab; // Converter result per channel
	logic [3:0][15:0] lim; // Warn lo, warn hi, alarm lo, alarm hi
	int n_fail, checked;
	mrlf_top #(.FRAME_CYCLES(50)) i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .conv_start_o, .conv_chan_o, .conv_done_i,
		.conv_data_i, .buffer_a_logic_in, .buffer_b_logic_in, .write_protect_pin,
		.buffer_a_open_drain_out, .buffer_a_open_drain_oe, .buffer_b_open_drain_out,
		.buffer_b_open_drain_oe, .irq_o);
	mrlf_conv_model i_conv (.clk_i, .rst_i, .conv_start_i(conv_start_o),
		.conv_chan_i(conv_chan_o), .conv_done_o(conv_done_i),
		.conv_data_o(conv_data_i), .delay_i(dly), .tab_i(tab));
	// Clock, 8 ns period
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Classic cycle, held until ack is seen
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i} <= 3'h7;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		{cyc_i, stb_i, we_i} <= 3'h0;
	endtask
	// Read and compare only the bits under the mask
	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i} <= 3'h6;
		adr_i <= a;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		{cyc_i, stb_i} <= 2'h0;
		chk(dat_o & m, exp);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		rdm(a, 32'hFFFFFFFF, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Clears every sticky flag
	task automatic clr;
		wr(mrlf_pkg::ADR_DONE, 32'hFFFFFFFF);
		wr(mrlf_pkg::ADR_ALARM, 32'hFFFFFFFF);
		wr(mrlf_pkg::ADR_WARN, 32'hFFFFFFFF);
		wr(mrlf_pkg::ADR_IRQ_ST, 32'hFFFFFFFF);
	endtask
	task automatic close_out;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Watchdog far beyond the expected run
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		close_out();
	end
	initial begin
		{n_fail, checked} = 64'h0;
		{rst_i, cyc_i, stb_i, we_i} = 4'h8;
		{adr_i, sel_i, dat_i, dly} = {8'h00, 4'hF, 32'h0, 4'h1};
		{buffer_a_logic_in, buffer_b_logic_in, write_protect_pin} = 3'h7;
		tab = {16'h680F, 16'h0800, 16'h4007, 16'h8000, 16'h8000};
		lim = {16'h2000, 16'h6000, 16'h1000, 16'h7000};
		idle(8);
		rst_i <= 1'b0;
		wr(mrlf_pkg::ADR_CTRL, 32'h3);
		rdc(mrlf_pkg::ADR_CTRL, 32'h0);
		rdc(mrlf_pkg::ADR_IRQ_MSK, 32'h0);
		rdm(mrlf_pkg::ADR_STAT, 32'h00000001, 32'h00000001);
		write_protect_pin <= 1'b0;
		wr(8'h14, 32'hFFFFFFFF);
		rdc(8'h14, 32'h0);
		rdm(mrlf_pkg::ADR_STAT, 32'h00000001, 32'h00000000);
		$display("test reset and protect done");
		// Same window on all channels; temperature compares signed
		for (int c = 0; c < 5; c++) begin
			for (int k = 0; k < 4; k++) begin
				wr(mrlf_pkg::ADR_LIMIT0 + 8'(16 * c + 4 * k), {16'h0, lim[k]});
			end
		end
		rdc(mrlf_pkg::ADR_LIMIT0 + 8'h4C, {16'h0, lim[3]});
		clr();
		idle(60);
		for (int c = 0; c < 5; c++) begin
			rdc(mrlf_pkg::ADR_RESULT0 + 8'(4 * c), {16'h0, tab[c]});
		end
		rdc(mrlf_pkg::ADR_DONE, 32'h1F);
		rdc(mrlf_pkg::ADR_ALARM, 32'h86);
		rdc(mrlf_pkg::ADR_WARN, 32'h186);
		rdc(mrlf_pkg::ADR_IRQ_ST, 32'h1B);
		chk(32'(irq_o), 32'h0);
		$display("test limits done");
		wr(mrlf_pkg::ADR_IRQ_MSK, 32'h04);
		idle(2);
		chk(32'(irq_o), 32'h0);
		wr(mrlf_pkg::ADR_IRQ_MSK, 32'h08);
		idle(2);
		chk(32'(irq_o), 32'h1);
		// Slow converter, three lowest bits cleared, one channel back in range
		dly <= 4'h7;
		tab[3] <= 16'h4000;
		wr(mrlf_pkg::ADR_CTRL, 32'h3);
		idle(60);
		clr();
		idle(60);
		rdc(mrlf_pkg::ADR_RESULT0 + 8'h08, 32'h4000);
		rdc(mrlf_pkg::ADR_RESULT0 + 8'h10, 32'h6808);
		rdm(mrlf_pkg::ADR_RESULT0 + 8'h10, 32'h0000FFF0, 32'h00006800);
		rdc(mrlf_pkg::ADR_ALARM, 32'h06);
		chk(32'(irq_o), 32'h0);
		$display("test masking and interrupt done");
		for (int v = 0; v < 2; v++) begin
			buffer_a_logic_in <= v[0];
			buffer_b_logic_in <= v[0];
			idle(4);
			chk(32'(buffer_b_open_drain_oe), 32'(!v[0]));
			chk(32'(buffer_a_open_drain_oe), 32'h1);
		end
		wr(mrlf_pkg::ADR_CTRL, 32'h2);
		idle(2);
		chk(32'(buffer_a_open_drain_oe), 32'h0);
		$display("test buffers done");
		close_out();
	end
endmodule // test_monitor_readout_limit_flags
`default_nettype wire
